// >>> bench/ulsf_line_status_tb_top.sv
`default_nettype none
`include "ulsf_consts.svh"

module ulsf_line_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rx_line;
  logic        take;
  logic        sh_empty;
  logic [7:0]  hold_data;
  logic        hold_valid;
  logic        irq;
  int          bad_count = 0;
  int          check_count = 0;
  int          n;

  always #20 hclk = ~hclk;

  ulsf_line_status #(.BAUD_DIV(2), .FIFO_AW(4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_rx_input(rx_line), .tx_shift_take(take), .tx_shift_empty(sh_empty),
    .tx_holding_data(hold_data), .tx_holding_valid(hold_valid), .irq(irq)
  );

  ulsf_remote_uart #(.BIT_CLKS(32)) far_u (
    .hclk(hclk), .hresetn(hresetn), .serial_rx_input(rx_line),
    .tx_holding_data(hold_data), .tx_holding_valid(hold_valid),
    .tx_shift_take(take), .tx_shift_empty(sh_empty)
  );

  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    results();
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) hang();
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `ULSF_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(v, exp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`ULSF_ADDR_LSR, 32'h0000_0060);
    wr(`ULSF_ADDR_LSR, 32'h0000_00ff);
    rd(`ULSF_ADDR_LSR, 32'h0000_0060);
    rd(32'he001_0030, 32'h0000_0000);
    rd(`ULSF_ADDR_CTRL, 32'h0000_0000);
    rd(`ULSF_ADDR_IMASK, 32'h0000_0000);
    rd(`ULSF_ADDR_ISTAT, 32'h0000_0000);
    // transmit flags and holding-empty interrupt
    wr(`ULSF_ADDR_RXTX, 32'h0000_005a);
    rd(`ULSF_ADDR_LSR, 32'h0000_0000);
    chk({24'h0, hold_data}, 32'h0000_005a);
    chk({31'h0, hresp}, 32'h0000_0000);
    n = 0;
    while (hold_valid !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    if (hold_valid !== 1'b0) hang();
    rd(`ULSF_ADDR_LSR, 32'h0000_0020);
    n = 0;
    while (sh_empty !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    if (sh_empty !== 1'b1) hang();
    repeat (3) @(posedge hclk);
    rd(`ULSF_ADDR_LSR, 32'h0000_0060);
    chk({24'h0, far_u.last_byte}, 32'h0000_005a);
    rd(`ULSF_ADDR_ISTAT, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`ULSF_ADDR_IMASK, 32'h0000_0004);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`ULSF_ADDR_ISTAT, 32'h0000_0004);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(`ULSF_ADDR_ISTAT, 32'h0000_0000);
    // parity in both senses, fifo off
    for (int odd = 0; odd < 2; odd++) begin
      for (int bad = 0; bad < 2; bad++) begin
        wr(`ULSF_ADDR_CTRL, {29'h0, odd[0], 2'b10});
        far_u.send_char(8'h3c, 1'b1, odd[0], bad[0], 1'b1, 1'b1);
        repeat (4) @(posedge hclk);
        rd(`ULSF_ADDR_LSR, (bad != 0) ? 32'h0000_00e5 : 32'h0000_0061);
        rd(`ULSF_ADDR_RXTX, 32'h0000_003c);
        if (bad != 0) rd(`ULSF_ADDR_LSR, 32'h0000_00e0);
        rd(`ULSF_ADDR_LSR, 32'h0000_0060);
      end
    end
    // low stop bit taken as next start, fifo on
    wr(`ULSF_ADDR_CTRL, 32'h0000_0001);
    far_u.send_char(8'h81, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    far_u.send_char(8'h5a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge hclk);
    rd(`ULSF_ADDR_LSR, 32'h0000_00e9);
    rd(`ULSF_ADDR_LSR, 32'h0000_00e1);
    rd(`ULSF_ADDR_RXTX, 32'h0000_0081);
    rd(`ULSF_ADDR_RXTX, 32'h0000_005a);
    rd(`ULSF_ADDR_LSR, 32'h0000_00e0);
    rd(`ULSF_ADDR_LSR, 32'h0000_0060);
    // long break behind a clean character
    wr(`ULSF_ADDR_ISTAT, 32'h0000_0007);
    far_u.send_char(8'h11, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    far_u.drive(1'b0, 30);
    far_u.drive(1'b1, 2);
    far_u.send_char(8'ha5, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge hclk);
    rd(`ULSF_ADDR_LSR, 32'h0000_0061);
    rd(`ULSF_ADDR_RXTX, 32'h0000_0011);
    rd(`ULSF_ADDR_LSR, 32'h0000_00f1);
    rd(`ULSF_ADDR_LSR, 32'h0000_00e1);
    rd(`ULSF_ADDR_ISTAT, 32'h0000_0003);
    wr(`ULSF_ADDR_ISTAT, 32'h0000_0003);
    rd(`ULSF_ADDR_ISTAT, 32'h0000_0000);
    rd(`ULSF_ADDR_RXTX, 32'h0000_0000);
    rd(`ULSF_ADDR_RXTX, 32'h0000_00a5);
    rd(`ULSF_ADDR_LSR, 32'h0000_00e0);
    rd(`ULSF_ADDR_LSR, 32'h0000_0060);
    // break with fifo off shows at once
    wr(`ULSF_ADDR_CTRL, 32'h0000_0000);
    far_u.drive(1'b0, 12);
    far_u.drive(1'b1, 2);
    rd(`ULSF_ADDR_LSR, 32'h0000_00f1);
    rd(`ULSF_ADDR_RXTX, 32'h0000_0000);
    rd(`ULSF_ADDR_LSR, 32'h0000_00e0);
    rd(`ULSF_ADDR_LSR, 32'h0000_0060);
    results();
  end

endmodule

`default_nettype wire

// >>> bench/ulsf_remote_uart.sv
`default_nettype none

module ulsf_remote_uart #(
  parameter int BIT_CLKS = 32
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // serial line toward the block
  output var  logic       serial_rx_input,
  // transmit shift register side
  input  wire logic [7:0] tx_holding_data,
  input  wire logic       tx_holding_valid,
  output var  logic       tx_shift_take,
  output var  logic       tx_shift_empty
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // remote transmitter
  // ----------------------------------------
  int         lag      = 8;
  int         busy_len = 60;
  int         wait_c;
  int         busy_c;
  logic [7:0] last_byte;

  initial serial_rx_input = 1'b1;

  task automatic drive(input logic v, input int nbits);
    @(posedge hclk);
    serial_rx_input <= v;
    repeat (nbits * BIT_CLKS - 1) @(posedge hclk);
  endtask

  task automatic send_char(input logic [7:0] d, input logic par_en, input logic odd,
                           input logic bad_par, input logic stop_lvl, input logic start);
    int i;
    if (start) drive(1'b0, 1);
    for (i = 0; i < 8; i++) drive(d[i], 1);
    if (par_en) drive(^d ^ odd ^ bad_par, 1);
    drive(stop_lvl, 1);
  endtask

  // ----------------------------------------
  // shift register, slow to take and to drain
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_shift_take <= 1'b0;
      tx_shift_empty <= 1'b1;
      wait_c <= 0;
      busy_c <= 0;
      last_byte <= 8'h00;
    end else begin
      tx_shift_take <= 1'b0;
      if (busy_c > 0) begin
        busy_c <= busy_c - 1;
        tx_shift_empty <= (busy_c == 1);
      end else if (tx_holding_valid && tx_shift_empty && !tx_shift_take) begin
        if (wait_c < lag) begin
          wait_c <= wait_c + 1;
        end else begin
          tx_shift_take <= 1'b1;
          tx_shift_empty <= 1'b0;
          busy_c <= busy_len;
          wait_c <= 0;
          last_byte <= tx_holding_data;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> inc/ulsf_consts.svh
`ifndef ULSF_CONSTS_SVH
`define ULSF_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ULSF_ADDR_RXTX     32'he001_0000
`define ULSF_ADDR_LSR      32'he001_0014
`define ULSF_ADDR_CTRL     32'he001_0040
`define ULSF_ADDR_ISTAT    32'he001_0044
`define ULSF_ADDR_IMASK    32'he001_0048

// ----------------------------------------
// line status bit positions
// ----------------------------------------
`define ULSF_LSR_DR        0
`define ULSF_LSR_PERR      2
`define ULSF_LSR_FERR      3
`define ULSF_LSR_BRK       4
`define ULSF_LSR_THR_EMPTY 5
`define ULSF_LSR_ALL_EMPTY 6
`define ULSF_LSR_RXERR     7

// ----------------------------------------
// control and interrupt fields
// ----------------------------------------
`define ULSF_CTRL_FIFO_EN  0
`define ULSF_CTRL_PAR_EN   1
`define ULSF_CTRL_PAR_ODD  2
`define ULSF_CTRL_W        3
`define ULSF_CTRL_RST      3'h0
`define ULSF_INT_BRK       0
`define ULSF_INT_RXERR     1
`define ULSF_INT_TX_HOLDING_EMPTY      2
`define ULSF_INT_W         3
`define ULSF_INT_RST       3'h0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define ULSF_THR_EMPTY_RST 1'h1
`define ULSF_ALL_EMPTY_RST 1'h1
`define ULSF_OVS_LAST      4'hf
`define ULSF_HALF_LAST     4'h7
`define ULSF_DATA_LAST     3'h7
`define ULSF_HTRANS_NONSEQ 2'h2
`define ULSF_BAUD_DIV      163
`define ULSF_FIFO_AW       4

`endif

// >>> inc/ulsf_pkg.sv
`default_nettype none
`include "ulsf_consts.svh"

package ulsf_pkg;

  // ----------------------------------------
  // receiver types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_BRK   = 3'b101
  } ulsf_rx_state_t;

  typedef struct packed {
    logic       brk;
    logic       ferr;
    logic       perr;
    logic [7:0] data;
  } ulsf_rx_entry_t;

  typedef struct packed {
    ulsf_rx_state_t state;
    logic           sync1;
    logic           sync2;
    logic [3:0]     cnt;
    logic [2:0]     bitn;
    logic [7:0]     shreg;
    logic           par;
    logic           all_low;
  } ulsf_rx_st_t;

  // ----------------------------------------
  // top state
  // ----------------------------------------
  typedef struct packed {
    ulsf_rx_st_t                rx;
    logic [`ULSF_CTRL_W-1:0]    ctrl;
    logic [7:0]                 thr;
    logic                       thr_full;
    logic                       all_empty;
    logic                       perr;
    logic                       ferr;
    logic                       brk;
    logic                       rxerr;
    logic [`ULSF_FIFO_AW:0]     err_cnt;
    logic                       head_new;
    logic [`ULSF_INT_W-1:0]     istat;
    logic [`ULSF_INT_W-1:0]     imask;
    logic                       irq;
    logic                       d_wr;
    logic [31:0]                d_addr;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
  } ulsf_top_st_t;

endpackage

`default_nettype wire

// >>> verilog/ulsf_line_status.sv
// How it works
// R01 - a break is flagged when the receive line stays low for a whole character incl. stop.
// R02 - after a break the receiver idles until the receive line returns high.
// R03 - reading the line status register clears the break flag.
// R04 - break is reported with the head character; fifo enable decides when it shows.
// R05 - holding-empty sets as soon as the holding register empties, clears on write, resets 1.
// R06 - all-empty is 1 only while holding and shift registers are both empty, resets 1.
// R07 - bit 7 sets when a character with framing, parity or break error reaches the head.
// R08 - bit 7 clears on a status read only when no errored characters remain queued.
// R09 - the line status register is read only at its fixed address; writes do nothing.
// R10 - a wrong parity bit sets the parity flag, cleared by a status read.
// R11 - a low stop bit sets the framing flag and is taken as the next start bit.
// R12 - break, holding-empty and all-empty sit at status bits 4, 5 and 6.
// R13 - flags update on the clock and a set in the read cycle beats the clear.
`default_nettype none
`include "ulsf_consts.svh"

module ulsf_line_status #(
  parameter int BAUD_DIV = `ULSF_BAUD_DIV,
  parameter int FIFO_AW  = `ULSF_FIFO_AW
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial line
  input  wire logic        serial_rx_input,
  // transmit shift register side
  input  wire logic        tx_shift_take,
  input  wire logic        tx_shift_empty,
  output logic      [7:0]  tx_holding_data,
  output logic             tx_holding_valid,
  // interrupt
  output logic             irq
);
  import ulsf_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  ulsf_top_st_t          s_r;
  ulsf_top_st_t          s_nxt;
  logic                  tick;
  logic                  rxd;
  logic                  fifo_en;
  logic                  par_en;
  logic                  par_odd;
  logic                  a_ok;
  logic                  rd_lsr;
  logic                  rd_rbr;
  logic                  wr_thr;
  logic                  push;
  ulsf_rx_entry_t        rxe;
  ulsf_rx_entry_t        head;
  ulsf_rx_entry_t        hl;
  logic                  hl_set;
  logic                  hl_err;
  logic                  push_err;
  logic                  pop_err;
  logic [FIFO_AW:0]      fifo_cnt;
  logic [FIFO_AW:0]      err_nxt;
  logic [7:0]            lsr;
  logic [`ULSF_INT_W-1:0] ev;
  logic [`ULSF_INT_W-1:0] w1c;

  // ----------------------------------------
  // oversample divider and receive queue
  // ----------------------------------------
  ulsf_tick_div #(
    .DIV     (BAUD_DIV)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  ulsf_rx_fifo #(
    .W       ($bits(ulsf_rx_entry_t)),
    .AW      (FIFO_AW)
  ) u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (push),
    .wdata   (rxe),
    .pop     (rd_rbr),
    .rdata   (head),
    .count   (fifo_cnt)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt          = s_r;
    push           = 1'b0;
    rxe            = '0;
    s_nxt.rx.sync1 = serial_rx_input;
    s_nxt.rx.sync2 = s_r.rx.sync1;
    rxd            = s_r.rx.sync2;
    fifo_en        = s_r.ctrl[`ULSF_CTRL_FIFO_EN];
    par_en         = s_r.ctrl[`ULSF_CTRL_PAR_EN];
    par_odd        = s_r.ctrl[`ULSF_CTRL_PAR_ODD];

    // bus address phase
    a_ok   = hsel & hready & (htrans == `ULSF_HTRANS_NONSEQ);
    rd_lsr = a_ok & !hwrite & (haddr == `ULSF_ADDR_LSR);
    rd_rbr = a_ok & !hwrite & (haddr == `ULSF_ADDR_RXTX) & (fifo_cnt != '0);
    s_nxt.d_wr = a_ok & hwrite;
    if (a_ok) begin
      s_nxt.d_addr = haddr;
    end
    wr_thr = s_r.d_wr & (s_r.d_addr == `ULSF_ADDR_RXTX);

    // receiver
    unique case (s_r.rx.state)
      RX_IDLE: begin
        if (!rxd) begin
          s_nxt.rx.state   = RX_START;
          s_nxt.rx.cnt     = '0;
          s_nxt.rx.all_low = 1'b1;
        end
      end
      RX_START: begin
        if (tick) begin
          s_nxt.rx.cnt = s_r.rx.cnt + 4'h1;
          if (s_r.rx.cnt == `ULSF_HALF_LAST) begin
            s_nxt.rx.cnt   = '0;
            s_nxt.rx.bitn  = '0;
            s_nxt.rx.state = rxd ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          s_nxt.rx.cnt = s_r.rx.cnt + 4'h1;
          if (s_r.rx.cnt == `ULSF_OVS_LAST) begin
            s_nxt.rx.shreg   = {rxd, s_r.rx.shreg[7:1]};
            s_nxt.rx.all_low = s_r.rx.all_low & !rxd; // R01
            s_nxt.rx.bitn    = s_r.rx.bitn + 3'h1;
            if (s_r.rx.bitn == `ULSF_DATA_LAST) begin
              s_nxt.rx.state = par_en ? RX_PAR : RX_STOP;
            end
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          s_nxt.rx.cnt = s_r.rx.cnt + 4'h1;
          if (s_r.rx.cnt == `ULSF_OVS_LAST) begin
            s_nxt.rx.par     = rxd;
            s_nxt.rx.all_low = s_r.rx.all_low & !rxd; // R01
            s_nxt.rx.state   = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          s_nxt.rx.cnt = s_r.rx.cnt + 4'h1;
          if (s_r.rx.cnt == `ULSF_OVS_LAST) begin
            push     = 1'b1;
            rxe.data = s_r.rx.shreg;
            rxe.perr = par_en & ((^s_r.rx.shreg ^ s_r.rx.par) != par_odd); // R10
            if (rxd) begin
              s_nxt.rx.state = RX_IDLE;
            end else if (s_r.rx.all_low) begin
              rxe            = '0;
              rxe.brk        = 1'b1; // R01
              s_nxt.rx.state = RX_BRK;
            end else begin
              rxe.ferr         = 1'b1; // R11
              s_nxt.rx.state   = RX_DATA; // R11
              s_nxt.rx.bitn    = '0;
              s_nxt.rx.all_low = 1'b1;
            end
          end
        end
      end
      RX_BRK: begin
        if (rxd) begin
          s_nxt.rx.state = RX_IDLE; // R02
        end
      end
      default: begin
        s_nxt.rx.state = RX_IDLE;
      end
    endcase

    // head of queue reaches the status word
    s_nxt.head_new = fifo_en & ((push & ((fifo_cnt == '0) | (rd_rbr & (fifo_cnt == 1))))
                     | (rd_rbr & (fifo_cnt > 1))); // R04
    hl_set   = fifo_en ? s_r.head_new : push; // R04
    hl       = fifo_en ? head : rxe; // R04
    hl_err   = hl.brk | hl.ferr | hl.perr;
    push_err = push & (rxe.brk | rxe.ferr | rxe.perr);
    pop_err  = rd_rbr & (head.brk | head.ferr | head.perr);
    err_nxt  = s_r.err_cnt + {{FIFO_AW{1'b0}}, push_err} - {{FIFO_AW{1'b0}}, pop_err};
    s_nxt.err_cnt = err_nxt;

    // sticky error flags, set beats clear
    s_nxt.perr  = (hl_set & hl.perr) | (s_r.perr & !rd_lsr); // R10 R13
    s_nxt.ferr  = (hl_set & hl.ferr) | (s_r.ferr & !rd_lsr); // R11 R13
    s_nxt.brk   = (hl_set & hl.brk) | (s_r.brk & !rd_lsr); // R03 R13
    s_nxt.rxerr = (hl_set & hl_err) | (s_r.rxerr & !(rd_lsr & (err_nxt == '0))); // R07 R08 R13

    // transmit holding and shift status
    if (wr_thr) begin
      s_nxt.thr      = hwdata[7:0];
      s_nxt.thr_full = 1'b1; // R05
    end else if (tx_shift_take) begin
      s_nxt.thr_full = 1'b0; // R05
    end
    s_nxt.all_empty = !s_nxt.thr_full & tx_shift_empty; // R06

    // control and interrupt registers
    if (s_r.d_wr & (s_r.d_addr == `ULSF_ADDR_CTRL)) begin
      s_nxt.ctrl = hwdata[`ULSF_CTRL_W-1:0];
    end
    if (s_r.d_wr & (s_r.d_addr == `ULSF_ADDR_IMASK)) begin
      s_nxt.imask = hwdata[`ULSF_INT_W-1:0];
    end
    w1c = (s_r.d_wr & (s_r.d_addr == `ULSF_ADDR_ISTAT)) ? hwdata[`ULSF_INT_W-1:0] : '0;
    ev  = '0;
    ev[`ULSF_INT_BRK]   = hl_set & hl.brk;
    ev[`ULSF_INT_RXERR] = hl_set & hl_err;
    ev[`ULSF_INT_TX_HOLDING_EMPTY]  = s_r.thr_full & !s_nxt.thr_full;
    s_nxt.istat = ev | (s_r.istat & ~w1c);
    s_nxt.irq   = |(s_nxt.istat & s_nxt.imask);

    // read data, status word is read only
    lsr                 = '0; // R09
    lsr[`ULSF_LSR_DR]        = (fifo_cnt != '0);
    lsr[`ULSF_LSR_PERR]      = s_r.perr;
    lsr[`ULSF_LSR_FERR]      = s_r.ferr;
    lsr[`ULSF_LSR_BRK]       = s_r.brk; // R12
    lsr[`ULSF_LSR_THR_EMPTY] = !s_r.thr_full; // R12
    lsr[`ULSF_LSR_ALL_EMPTY] = s_r.all_empty; // R12
    lsr[`ULSF_LSR_RXERR]     = s_r.rxerr;
    s_nxt.hrdata = 32'h0000_0000;
    if (a_ok & !hwrite) begin
      unique case (haddr)
        `ULSF_ADDR_LSR:   s_nxt.hrdata = {24'h00_0000, lsr}; // R09
        `ULSF_ADDR_RXTX:  s_nxt.hrdata = {24'h00_0000, head.data};
        `ULSF_ADDR_CTRL:  s_nxt.hrdata = {29'h0000_0000, s_r.ctrl};
        `ULSF_ADDR_ISTAT: s_nxt.hrdata = {29'h0000_0000, s_r.istat};
        `ULSF_ADDR_IMASK: s_nxt.hrdata = {29'h0000_0000, s_r.imask};
        default:          s_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp     = 1'b0;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r           <= '0;
      s_r.rx.sync1  <= 1'b1;
      s_r.rx.sync2  <= 1'b1;
      s_r.ctrl      <= `ULSF_CTRL_RST;
      s_r.thr_full  <= !`ULSF_THR_EMPTY_RST; // R05
      s_r.all_empty <= `ULSF_ALL_EMPTY_RST; // R06
      s_r.istat     <= `ULSF_INT_RST;
      s_r.imask     <= `ULSF_INT_RST;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt; // R13
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata           = s_r.hrdata;
  assign hreadyout        = s_r.hreadyout;
  assign hresp            = s_r.hresp;
  assign tx_holding_data  = s_r.thr;
  assign tx_holding_valid = s_r.thr_full;
  assign irq              = s_r.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_brk_set;
    (push && rxe.brk && !fifo_en) |=> s_r.brk && s_r.rxerr && s_r.rx.state == RX_BRK;
  endproperty
  a_brk_set: assert property (p_brk_set) else $error("break not flagged"); // R01

  property p_brk_idle;
    (s_r.rx.state == RX_BRK && !rxd) |=> (s_r.rx.state == RX_BRK && !push);
  endproperty
  a_brk_idle: assert property (p_brk_idle) else $error("receiver left break early"); // R02

  property p_rd_clear;
    (rd_lsr && !hl_set) |=> !s_r.brk && !s_r.perr && !s_r.ferr;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear"); // R03

  property p_fifo_vis;
    (fifo_en && push && rxe.brk && fifo_cnt == '0 && !rd_rbr) |=> s_r.head_new ##1 s_r.brk;
  endproperty
  a_fifo_vis: assert property (p_fifo_vis) else $error("queued break not shown"); // R04

  property p_hold_full;
    wr_thr |=> (s_r.thr_full && !lsr[`ULSF_LSR_THR_EMPTY]);
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("holding empty after write"); // R05

  property p_all_empty;
    (s_r.thr_full || !$past(tx_shift_empty)) |-> !s_r.all_empty;
  endproperty
  a_all_empty: assert property (p_all_empty) else $error("all-empty with data held"); // R06

  property p_rxerr_set;
    (hl_set && hl_err) |=> s_r.rxerr;
  endproperty
  a_rxerr_set: assert property (p_rxerr_set) else $error("error summary not set"); // R07

  property p_rxerr_hold;
    (s_r.rxerr && err_nxt != '0) |=> s_r.rxerr;
  endproperty
  a_rxerr_hold: assert property (p_rxerr_hold) else $error("error summary cleared early"); // R08

  property p_ro;
    (s_r.d_wr && s_r.d_addr == `ULSF_ADDR_LSR && !hl_set && !rd_lsr)
      |=> $stable({s_r.perr, s_r.ferr, s_r.brk, s_r.rxerr});
  endproperty
  a_ro: assert property (p_ro) else $error("status written by software"); // R09

  property p_parity;
    (push && rxe.perr && !fifo_en) |=> s_r.perr;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag missed"); // R10

  property p_frame;
    (push && rxe.ferr) |=> (s_r.rx.state == RX_DATA && s_r.rx.bitn == 3'h0);
  endproperty
  a_frame: assert property (p_frame) else $error("no resync after framing"); // R11

  property p_setwin;
    (rd_lsr && hl_set && hl.brk) |=> s_r.brk;
  endproperty
  a_setwin: assert property (p_setwin) else $error("break lost to read"); // R13

  c_brk:   cover property (push && rxe.brk);
  c_frame: cover property (push && rxe.ferr);
  c_irq:   cover property (!s_r.irq ##1 s_r.irq);
endmodule

`default_nettype wire

// >>> verilog/ulsf_rx_fifo.sv
`default_nettype none

module ulsf_rx_fifo #(
  parameter int W  = 11,
  parameter int AW = 4
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // write side
  input  wire logic          push,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic          pop,
  output logic      [W-1:0]  rdata,
  output logic      [AW:0]   count
);
  localparam int          D    = 1 << AW;
  localparam logic [AW:0] FULL = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic [W-1:0]        rd;
  } ulsf_fifo_st_t;

  ulsf_fifo_st_t s_r;
  ulsf_fifo_st_t s_nxt;
  logic          do_push;
  logic          do_pop;

  always_comb begin
    s_nxt   = s_r;
    do_push = push & (s_r.cnt != FULL);
    do_pop  = pop & (s_r.cnt != '0);
    if (do_push) begin
      s_nxt.mem[s_r.wp] = wdata;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    s_nxt.rd  = s_nxt.mem[s_nxt.rp];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rd;
  assign count = s_r.cnt;
endmodule

`default_nettype wire

// >>> verilog/ulsf_tick_div.sv
`default_nettype none
`include "ulsf_consts.svh"

module ulsf_tick_div #(
  parameter int DIV = `ULSF_BAUD_DIV
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // oversample enable
  output logic      tick
);
  import ulsf_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ulsf_div_st_t;

  localparam logic [15:0] LAST = 16'(DIV - 1);

  ulsf_div_st_t s_r;
  ulsf_div_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = (s_r.cnt == LAST);
    s_nxt.cnt  = s_nxt.tick ? 16'h0000 : s_r.cnt + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

`default_nettype wire
